/* File: hw/csm_clock_select.sv */
// Purpose: clock source selection for pre-scaler, bit-clock and ratio dividers
// Assumes: source clocks arrive asynchronously and are far slower than sys_clk
// Notes: outputs are sampled clock levels; latency is sync depth plus two cycles
`timescale 1ns/1ps
module csm_clock_select (
    // clock, reset, enable
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // register port
    input  wire logic [csm_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [csm_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [csm_pkg::DATA_W-1:0]  reg_rdata,
    // mode
    input  wire logic                        custom_clock_mode,
    // source clocks
    input  wire logic                        primary_serial_port_bitclk,
    input  wire logic                        secondary_serial_port_bitclk,
    input  wire logic                        controller_clock,
    input  wire logic                        pll_output_clock,
    input  wire logic                        oscillator_clock,
    input  wire logic                        dsp_clock,
    // selected clocks
    output logic                             prescaler_input_clock,
    output logic                             primary_bitclk_divider_clock,
    output logic                             secondary_bitclk_divider_clock,
    output logic                             digital_ratio_divider_clock,
    output logic                             analog_ratio_divider_clock,
    // status
    output logic                             osc_misuse
);
    logic [7:0]                  pre_pri_reg;
    logic [7:0]                  sec_reg;
    logic [7:0]                  nm_reg;
    logic [csm_pkg::NUM_SRC-1:0] src_raw;
    logic [csm_pkg::NUM_SRC-1:0] sync1_reg;
    logic [csm_pkg::NUM_SRC-1:0] sync2_reg;
    logic [csm_pkg::NUM_SRC-1:0] sync3_reg;
    logic [csm_pkg::NUM_SRC-1:0] clean_reg;
    logic [1:0]                  prescaler_source_select;
    logic [2:0]                  primary_bitclk_divider_source;
    logic [2:0]                  secondary_bitclk_divider_source;
    logic [1:0]                  digital_ratio_divider_source;
    logic [1:0]                  analog_ratio_divider_source;
    logic [3:0]                  pre_src;
    logic [7:0]                  pri_src;
    logic [7:0]                  sec_src;
    logic [3:0]                  dig_src;
    logic [3:0]                  ana_src;
    logic                        pre_ok;
    logic                        pri_ok;
    logic                        sec_ok;
    logic                        dig_ok;
    logic                        ana_ok;
    logic                        osc_picked;
    logic [7:0]                  status_word;

    assign src_raw = {dsp_clock, oscillator_clock, pll_output_clock,
                      controller_clock, secondary_serial_port_bitclk,
                      primary_serial_port_bitclk};

    // three-stage sync; a level is accepted only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < csm_pkg::NUM_SRC; g++)
        begin : g_sync
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                    sync3_reg[g] <= 1'b0;
                    clean_reg[g] <= 1'b0;
                end
                else if (ce)
                begin
                    sync1_reg[g] <= src_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                    sync3_reg[g] <= sync2_reg[g];
                    if (sync2_reg[g] == sync3_reg[g])
                    begin
                        clean_reg[g] <= sync3_reg[g];
                    end
                end
            end
        end
    endgenerate

    // register writes; reserved positions are forced to zero whatever is written
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pre_pri_reg <= csm_pkg::RST_PRE_PRI;
            sec_reg     <= csm_pkg::RST_SEC;
            nm_reg      <= csm_pkg::RST_NM;
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr == csm_pkg::OFF_PRE_PRI)
            begin
                pre_pri_reg <= reg_wdata & csm_pkg::MASK_PRE_PRI;
            end
            if (reg_addr == csm_pkg::OFF_SEC)
            begin
                sec_reg <= reg_wdata & csm_pkg::MASK_SEC;
            end
            if (reg_addr == csm_pkg::OFF_NM)
            begin
                nm_reg <= reg_wdata & csm_pkg::MASK_NM;
            end
        end
    end

    assign prescaler_source_select         = pre_pri_reg[csm_pkg::PRE_LSB +: 2];
    assign primary_bitclk_divider_source   = pre_pri_reg[csm_pkg::PRI_LSB +: 3];
    assign secondary_bitclk_divider_source = sec_reg[csm_pkg::SEC_LSB +: 3];
    assign digital_ratio_divider_source    = nm_reg[csm_pkg::DIG_LSB +: 2];
    assign analog_ratio_divider_source     = nm_reg[csm_pkg::ANA_LSB +: 2];

    // source tables, indexed by field code; reserved codes carry zero
    always_comb
    begin
        pre_src = {clean_reg[csm_pkg::SRC_OSC], clean_reg[csm_pkg::SRC_CTL],
                   clean_reg[csm_pkg::SRC_SEC], clean_reg[csm_pkg::SRC_PRI]};
        pri_src = {2'b00, clean_reg[csm_pkg::SRC_DSP], clean_reg[csm_pkg::SRC_OSC],
                   clean_reg[csm_pkg::SRC_CTL], clean_reg[csm_pkg::SRC_SEC],
                   1'b0, clean_reg[csm_pkg::SRC_PLL]};
        sec_src = {2'b00, clean_reg[csm_pkg::SRC_DSP], clean_reg[csm_pkg::SRC_OSC],
                   clean_reg[csm_pkg::SRC_CTL], 1'b0,
                   clean_reg[csm_pkg::SRC_PRI], clean_reg[csm_pkg::SRC_PLL]};
        dig_src = {clean_reg[csm_pkg::SRC_OSC], clean_reg[csm_pkg::SRC_CTL],
                   clean_reg[csm_pkg::SRC_SEC], clean_reg[csm_pkg::SRC_PRI]};
        // code 2 follows the digital divider's live choice, not its registered output
        ana_src = {clean_reg[csm_pkg::SRC_PRI], dig_src[digital_ratio_divider_source],
                   clean_reg[csm_pkg::SRC_PLL], clean_reg[csm_pkg::SRC_PLL]};
    end

    csm_clk_pick #(.SEL_W(2)) u_pre (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .sel     (prescaler_source_select),
        .src     (pre_src),
        .legal   (csm_pkg::LEGAL_2BIT),
        .clk_out (prescaler_input_clock),
        .sel_ok  (pre_ok)
    );

    csm_clk_pick #(.SEL_W(3)) u_pri (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .sel     (primary_bitclk_divider_source),
        .src     (pri_src),
        .legal   (csm_pkg::LEGAL_PRI),
        .clk_out (primary_bitclk_divider_clock),
        .sel_ok  (pri_ok)
    );

    csm_clk_pick #(.SEL_W(3)) u_sec (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .sel     (secondary_bitclk_divider_source),
        .src     (sec_src),
        .legal   (csm_pkg::LEGAL_SEC),
        .clk_out (secondary_bitclk_divider_clock),
        .sel_ok  (sec_ok)
    );

    csm_clk_pick #(.SEL_W(2)) u_dig (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .sel     (digital_ratio_divider_source),
        .src     (dig_src),
        .legal   (csm_pkg::LEGAL_2BIT),
        .clk_out (digital_ratio_divider_clock),
        .sel_ok  (dig_ok)
    );

    csm_clk_pick #(.SEL_W(2)) u_ana (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .sel     (analog_ratio_divider_source),
        .src     (ana_src),
        .legal   (csm_pkg::LEGAL_2BIT),
        .clk_out (analog_ratio_divider_clock),
        .sel_ok  (ana_ok)
    );

    // software owns the custom-mode check; the block only reports misuse
    assign osc_picked = (prescaler_source_select == csm_pkg::PRE_CODE_OSC)
                      | (primary_bitclk_divider_source == csm_pkg::PRI_CODE_OSC)
                      | (secondary_bitclk_divider_source == csm_pkg::SEC_CODE_OSC)
                      | (digital_ratio_divider_source == csm_pkg::DIG_CODE_OSC);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            osc_misuse <= 1'b0;
        end
        else if (ce)
        begin
            osc_misuse <= osc_picked & ~custom_clock_mode;
        end
    end

    always_comb
    begin
        status_word                         = 8'h00;
        status_word[csm_pkg::ST_PRE_OK]     = pre_ok;
        status_word[csm_pkg::ST_PRI_OK]     = pri_ok;
        status_word[csm_pkg::ST_SEC_OK]     = sec_ok;
        status_word[csm_pkg::ST_DIG_OK]     = dig_ok;
        status_word[csm_pkg::ST_ANA_OK]     = ana_ok;
        status_word[csm_pkg::ST_OSC_MISUSE] = osc_misuse;
    end

    // read data is valid in the cycle after an enabled strobe; zero after other enabled cycles, held while ce is low
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (ce)
        begin
            if (reg_rd)
            begin
                unique case (reg_addr)
                    csm_pkg::OFF_PRE_PRI: reg_rdata <= pre_pri_reg;
                    csm_pkg::OFF_SEC:     reg_rdata <= sec_reg;
                    csm_pkg::OFF_NM:      reg_rdata <= nm_reg;
                    csm_pkg::OFF_STATUS:  reg_rdata <= status_word;
                    default:              reg_rdata <= 8'h00;
                endcase
            end
            else
            begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule : csm_clock_select

/* File: hw/csm_pkg.sv */
// Purpose: shared constants for the clock source select block
// Assumes: 8-bit register port, byte offsets as printed
// Notes: field positions, masks, reset values and source codes live here
// Function
// - pre-scaler source field bits 7-6 picks primary, secondary, controller or oscillator clock.
// - primary divider field bits 5-3 picks pll, secondary, controller, oscillator, dsp.
// - secondary divider field bits 6-4 picks pll, primary, controller, oscillator, dsp.
// - digital ratio divider field bits 7-6 picks primary, secondary, controller, oscillator.
// - analog ratio field bits 5-4: pll, pll, digital source, primary; resets to 01b.
// - reserved bits read zero; software writes zero into them.
package csm_pkg;
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 8;
    localparam int         NUM_SRC         = 6;

    localparam logic [7:0] OFF_PRE_PRI     = 8'h32;
    localparam logic [7:0] OFF_SEC         = 8'h33;
    localparam logic [7:0] OFF_NM          = 8'h34;
    localparam logic [7:0] OFF_STATUS      = 8'h3F;

    localparam logic [7:0] RST_PRE_PRI     = 8'h00;
    localparam logic [7:0] RST_SEC         = 8'h00;
    localparam logic [7:0] RST_NM          = 8'h10;

    // writable bits; everything else is reserved and kept at zero
    localparam logic [7:0] MASK_PRE_PRI    = 8'hF8;
    localparam logic [7:0] MASK_SEC        = 8'h70;
    localparam logic [7:0] MASK_NM         = 8'hF0;

    localparam int         PRE_LSB         = 6;
    localparam int         PRI_LSB         = 3;
    localparam int         SEC_LSB         = 4;
    localparam int         DIG_LSB         = 6;
    localparam int         ANA_LSB         = 4;

    // index of each synchronised source clock
    localparam int         SRC_PRI         = 0;
    localparam int         SRC_SEC         = 1;
    localparam int         SRC_CTL         = 2;
    localparam int         SRC_PLL         = 3;
    localparam int         SRC_OSC         = 4;
    localparam int         SRC_DSP         = 5;

    // codes that select the oscillator in each field
    localparam logic [1:0] PRE_CODE_OSC    = 2'h3;
    localparam logic [2:0] PRI_CODE_OSC    = 3'h4;
    localparam logic [2:0] SEC_CODE_OSC    = 3'h4;
    localparam logic [1:0] DIG_CODE_OSC    = 2'h3;

    // legal code masks, bit n set when code n is defined
    localparam logic [3:0] LEGAL_2BIT      = 4'hF;
    localparam logic [7:0] LEGAL_PRI       = 8'h3D;
    localparam logic [7:0] LEGAL_SEC       = 8'h3B;

    localparam int         ST_PRE_OK       = 0;
    localparam int         ST_PRI_OK       = 1;
    localparam int         ST_SEC_OK       = 2;
    localparam int         ST_DIG_OK       = 3;
    localparam int         ST_ANA_OK       = 4;
    localparam int         ST_OSC_MISUSE   = 5;
endpackage : csm_pkg

/* File: hw/csm_clk_pick.sv */
// Purpose: one registered clock source selector
// Assumes: sources already synchronised to sys_clk
// Notes: a reserved code parks the output low instead of passing a stray source
`timescale 1ns/1ps
module csm_clk_pick #(
    parameter int SEL_W = 3
) (
    // clock and control
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // selection
    input  wire logic [SEL_W-1:0]      sel,
    input  wire logic [(1<<SEL_W)-1:0] src,
    input  wire logic [(1<<SEL_W)-1:0] legal,
    // result
    output logic                       clk_out,
    output logic                       sel_ok
);
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            clk_out <= 1'b0;
            sel_ok  <= 1'b0;
        end
        else if (ce)
        begin
            sel_ok  <= legal[sel];
            clk_out <= legal[sel] & src[sel];
        end
    end
endmodule : csm_clk_pick

/* File: testbench/csm_clock_select_checker.sv */
// Purpose: concurrent checks on the clock source select block
// Assumes: ce drops only briefly; run counters restart whenever it is low
// Notes: source checks wait eight steady cycles, well past the sync depth
`timescale 1ns/1ps
module csm_clock_select_checker (
    // clock and control
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       custom_clock_mode,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // source clocks
    input wire logic       primary_serial_port_bitclk,
    input wire logic       secondary_serial_port_bitclk,
    input wire logic       controller_clock,
    input wire logic       pll_output_clock,
    input wire logic       oscillator_clock,
    input wire logic       dsp_clock,
    // selected clocks
    input wire logic       prescaler_input_clock,
    input wire logic       primary_bitclk_divider_clock,
    input wire logic       secondary_bitclk_divider_clock,
    input wire logic       digital_ratio_divider_clock,
    input wire logic       analog_ratio_divider_clock,
    input wire logic       osc_misuse
);
    logic [5:0] srcs;
    logic [3:0] low_cnt_reg;
    logic [3:0] high_cnt_reg;
    assign srcs = {dsp_clock, oscillator_clock, pll_output_clock, controller_clock,
                   secondary_serial_port_bitclk, primary_serial_port_bitclk};
    // saturating run counters, so a long run never wraps back below the threshold
    always_ff @(posedge sys_clk)
    begin
        if (rst || !ce)
        begin
            low_cnt_reg  <= 4'h0;
            high_cnt_reg <= 4'h0;
        end
        else
        begin
            low_cnt_reg  <= (srcs != 6'h00) ? 4'h0 : low_cnt_reg + {3'h0, low_cnt_reg != 4'hF};
            high_cnt_reg <= (srcs != 6'h3F) ? 4'h0 : high_cnt_reg + {3'h0, high_cnt_reg != 4'hF};
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_rdata_idle: assert property ($past(ce && !reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_nm_rsvd: assert property (
        $past(ce && reg_rd && reg_addr == 8'h34) |-> reg_rdata[3:0] == 4'h0)
        else $error("ratio source reserved bits not zero");
    a_unmapped_zero: assert property (
        $past(ce && reg_rd && !(reg_addr inside {8'h32, 8'h33, 8'h34, 8'h3F}))
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_wr_rd_nm: assert property (
        (ce && reg_wr && reg_addr == 8'h34) ##1 (ce && reg_rd && reg_addr == 8'h34)
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'hF0)) else $error("ratio readback wrong");
    a_no_misuse: assert property ($past(ce && custom_clock_mode) |-> !osc_misuse)
        else $error("oscillator flag in custom mode");
    a_reset_quiet: assert property ($past(rst && ce) |->
        {prescaler_input_clock, primary_bitclk_divider_clock, secondary_bitclk_divider_clock,
        digital_ratio_divider_clock, analog_ratio_divider_clock, osc_misuse, reg_rdata}
        == 14'h0000) else $error("outputs after reset");
    a_low_follow: assert property (low_cnt_reg >= 4'h8 |->
        {prescaler_input_clock, primary_bitclk_divider_clock, secondary_bitclk_divider_clock,
        digital_ratio_divider_clock, analog_ratio_divider_clock} == 5'h00)
        else $error("clock high with all sources low");
    a_high_follow: assert property (high_cnt_reg >= 4'h8 |-> prescaler_input_clock
        && digital_ratio_divider_clock && analog_ratio_divider_clock)
        else $error("clock low with sources high");
    c_nm_read: cover property (ce && reg_rd && reg_addr == 8'h34);
    c_misuse: cover property ($rose(osc_misuse));
    c_high_run: cover property (high_cnt_reg == 4'h8);
endmodule : csm_clock_select_checker

bind csm_clock_select csm_clock_select_checker u_chk (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .custom_clock_mode(custom_clock_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .primary_serial_port_bitclk(primary_serial_port_bitclk),
    .secondary_serial_port_bitclk(secondary_serial_port_bitclk),
    .controller_clock(controller_clock), .pll_output_clock(pll_output_clock),
    .oscillator_clock(oscillator_clock), .dsp_clock(dsp_clock),
    .prescaler_input_clock(prescaler_input_clock),
    .primary_bitclk_divider_clock(primary_bitclk_divider_clock),
    .secondary_bitclk_divider_clock(secondary_bitclk_divider_clock),
    .digital_ratio_divider_clock(digital_ratio_divider_clock),
    .analog_ratio_divider_clock(analog_ratio_divider_clock), .osc_misuse(osc_misuse));

/* File: testbench/testbench.sv */
// Purpose: self-checking bench for the clock source select block
// Assumes: sources held steady while a selection is judged
// Notes: r32, r33 and r34 mirror what software believes is in the registers
`timescale 1ns/1ps
module testbench;
    logic       sys_clk, rst, ce, reg_wr, reg_rd, custom_clock_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, r32, r33, r34;
    logic [5:0] src;
    logic       pre_o, pri_o, sec_o, dig_o, ana_o, osc_misuse;
    logic [5:0] pats [3] = '{6'h2A, 6'h15, 6'h3F};
    int         errors, n_tests, k, rnd;
    int         seed = 32'h003d;

    csm_clock_select u_csm_clock_select (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .custom_clock_mode(custom_clock_mode), .primary_serial_port_bitclk(src[0]),
        .secondary_serial_port_bitclk(src[1]), .controller_clock(src[2]),
        .pll_output_clock(src[3]), .oscillator_clock(src[4]), .dsp_clock(src[5]),
        .prescaler_input_clock(pre_o), .primary_bitclk_divider_clock(pri_o),
        .secondary_bitclk_divider_clock(sec_o), .digital_ratio_divider_clock(dig_o),
        .analog_ratio_divider_clock(ana_o), .osc_misuse(osc_misuse));

    always #5 sys_clk = ~sys_clk;

    task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
        n_tests++;
        if (got !== want)
        begin
            errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask : check

    task automatic results();
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        reg_addr  <= a;
        reg_wdata <= d;
        case (a)
            8'h32: r32 = d & 8'hF8;
            8'h33: r33 = d & 8'h70;
            8'h34: r34 = d & 8'hF0;
            default: ;
        endcase
        @(posedge sys_clk);
    endtask : wr_reg

    // the strobe drops at the answering edge, so data is sampled just after it
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge sys_clk);
    endtask : rd_reg

    // upper byte is the status image, lower byte the selected levels and the misuse flag
    function automatic logic [15:0] expect_of(input logic [5:0] s, input logic cm);
        int   pre_map [4] = '{0, 1, 2, 4};
        int   pri_map [8] = '{3, -1, 1, 2, 4, 5, -1, -1};
        int   sec_map [8] = '{3, 0, -1, 2, 4, 5, -1, -1};
        int   p, q, w, d;
        logic ana, mis;
        p = pre_map[r32[7:6]];
        q = pri_map[r32[5:3]];
        w = sec_map[r33[6:4]];
        d = pre_map[r34[7:6]];
        ana = (r34[5:4] == 2'h2) ? s[d] : s[(r34[5:4] == 2'h3) ? 0 : 3];
        mis = !cm && (p == 4 || q == 4 || w == 4 || d == 4);
        return {2'h0, mis, 2'h3, w >= 0, q >= 0, 1'b1, 2'h0, mis, ana, s[d],
                (w < 0) ? 1'b0 : s[w], (q < 0) ? 1'b0 : s[q], s[p]};
    endfunction : expect_of

    task automatic check_sel();
        logic [15:0] e;
        logic [7:0]  st;
        logic [7:0]  got;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        e = expect_of(src, custom_clock_mode);
        got = {2'h0, osc_misuse, ana_o, dig_o, sec_o, pri_o, pre_o};
        check(got, e[7:0], "select");
        @(posedge sys_clk);
        rd_reg(8'h3F, st);
        check(st, e[15:8], "status");
    endtask : check_sel

    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        {reg_wr, reg_rd, custom_clock_mode, reg_addr, reg_wdata, src} = '0;
        {r32, r33, r34} = {8'h00, 8'h00, 8'h10};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd_reg(8'h32, v);
        check(v, 8'h00, "reset 32");
        rd_reg(8'h33, v);
        check(v, 8'h00, "reset 33");
        rd_reg(8'h34, v);
        check(v, 8'h10, "reset 34");
        wr_reg(8'h40, 8'hFF);
        rd_reg(8'h40, v);
        check(v, 8'h00, "unmapped");
        wr_reg(8'h32, 8'hFF);
        rd_reg(8'h32, v);
        check(v, 8'hF8, "mask 32");
        wr_reg(8'h33, 8'hFF);
        rd_reg(8'h33, v);
        check(v, 8'h70, "mask 33");
        wr_reg(8'h34, 8'hFF);
        rd_reg(8'h34, v);
        check(v, 8'hF0, "mask 34");
        // every code of every field, against three source patterns
        for (k = 0; k < 24; k++)
        begin
            src               <= pats[k % 3];
            custom_clock_mode <= k[0];
            v = 8'(k / 3);
            wr_reg(8'h32, {v[1:0], v[2:0], 3'h0});
            wr_reg(8'h33, {1'b0, v[2:0], 4'h0});
            wr_reg(8'h34, {v[1:0], v[1:0], 4'h0});
            check_sel();
        end
        // random selections; sources only change while nothing is being judged
        for (k = 0; k < 30; k++)
        begin
            rnd = $random(seed);
            src               <= rnd[5:0];
            custom_clock_mode <= rnd[6];
            wr_reg(8'h33, rnd[15:8] & 8'h70);
            wr_reg(8'h34, rnd[23:16] & 8'hF0);
            wr_reg(8'h32, rnd[31:24] & 8'hF8);
            check_sel();
        end
        // a write while ce is low must be lost, since ce freezes all state
        ce        <= 1'b0;
        reg_wr    <= 1'b1;
        reg_addr  <= 8'h34;
        reg_wdata <= ~r34;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        ce     <= 1'b1;
        rd_reg(8'h34, v);
        check(v, r34, "frozen write");
        // mid-run reset brings every field back, analog code 01b included
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        {r32, r33, r34} = {8'h00, 8'h00, 8'h10};
        rd_reg(8'h34, v);
        check(v, 8'h10, "reset again 34");
        check_sel();
        results();
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule : testbench
